// file: src/pmc_pkg.sv
package pmc_pkg;

    typedef enum logic [1:0] {
        PMC_FULL_ON = 2'h0,
        PMC_ACTIVE = 2'h1,
        PMC_SLEEP = 2'h2,
        PMC_DEEP_SLEEP = 2'h3
    } pmc_mode_e;

    // peripheral clock enable bit positions
    localparam int PCE_PCI = 0;
    localparam int PCE_EBIU = 1;
    localparam int PCE_FLAGS = 2;
    localparam int PCE_MDMA = 3;
    localparam int PCE_SPORT0 = 4;
    localparam int PCE_SPORT1 = 5;
    localparam int PCE_SPI0 = 6;
    localparam int PCE_SPI1 = 7;
    localparam int PCE_UART0 = 8;
    localparam int PCE_UART1 = 9;
    localparam int PCE_TMR0 = 10;
    localparam int PCE_TMR1 = 11;
    localparam int PCE_TMR2 = 12;
    localparam int PCE_USB = 13;
    localparam int PCE_W = 14;
    localparam logic [13:0] PCE_RESET = 14'h3fff;

    localparam logic [5:0] MULT_MIN = 6'h01;
    localparam logic [5:0] MULT_MAX = 6'h1f;
    localparam logic [1:0] SSEL_RESET = 2'h0;

    // system clock select: system clock half period in core clock cycles
    localparam logic [3:0] SSEL_HALF_2 = 4'h4;
    localparam logic [3:0] SSEL_HALF_25 = 4'h5;
    localparam logic [3:0] SSEL_HALF_3 = 4'h6;
    localparam logic [3:0] SSEL_HALF_4 = 4'h8;

    typedef struct packed {
        logic [5:0] mult;
        logic bypass;
        logic div_in;
        logic [1:0] ssel;
    } pmc_pll_s;

    // software mode request codes
    typedef enum logic [1:0] {
        PMC_REQ_RUN = 2'h0,
        PMC_REQ_SLEEP = 2'h1,
        PMC_REQ_DEEP = 2'h2,
        PMC_REQ_NONE = 2'h3
    } pmc_req_e;

endpackage : pmc_pkg

// file: src/pmc_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - full on: pll enabled, not bypassed
// - active: pll bypassed, core at half input
// - active allows system clock select change
// - active permits system dma to l1
// - sleep stops core, keeps pll and sysclk
// - sleep wakes on any interrupt, bypass selects
// - no system dma to l1 in sleep
// - deep sleep: pll off, all clocks stopped
// - deep sleep blocks async logic accesses
// - deep sleep exits only on reset/rtc
// - reset wake samples bypass pin
// - rtc wake enters full on, unless a reset wake comes in the same cycle
// - deep sleep indicator while in deep sleep
// - other changes only via programming sequence
// - per-peripheral clock enable bits gate clocks
// - multiplier 1x..31x from pins, then software
// - system clock driven onto output pin
// - select field sets core/system ratio
// - select reset value from two flag pins
module pmc_ctrl (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [5:0] mult_pin,
    input wire logic bypass_pin,
    input wire logic div_pin,
    input wire logic [1:0] ssel_pin,
    input wire logic pll_wr,
    input wire pmc_pkg::pmc_pll_s pll_wdata,
    input wire logic [1:0] mode_req,
    input wire logic seq_idle,
    input wire logic irq_any,
    input wire logic reset_irq,
    input wire logic rtc_irq,
    input wire logic pce_wr,
    input wire logic [13:0] pce_wdata,
    output logic [1:0] mode,
    output pmc_pkg::pmc_pll_s pll_control_register,
    output logic pll_enable,
    output logic pll_bypassed,
    output logic core_clk_en,
    output logic sys_clk_en,
    output logic core_half_rate,
    output logic sys_dma_ok,
    output logic async_access_ok,
    output logic deep_sleep_ind,
    output logic [13:0] periph_clk_en,
    output logic system_clock_output
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [9:0] pin_s1_reg;
    logic [9:0] pin_s2_reg;
    logic [2:0] irq_s1_reg;
    logic [2:0] irq_s2_reg;
    logic [9:0] pin_s1_next;
    logic [9:0] pin_s2_next;
    logic [2:0] irq_s1_next;
    logic [2:0] irq_s2_next;
    logic strap_done_reg;
    logic strap_done_next;
    logic [1:0] strap_sh_reg;
    logic [1:0] strap_sh_next;

    always_comb
    begin
        pin_s1_next = {mult_pin, bypass_pin, div_pin, ssel_pin};
        pin_s2_next = pin_s1_reg;
        irq_s1_next = {irq_any, reset_irq, rtc_irq};
        irq_s2_next = irq_s1_reg;
        // straps reach the second stage at the second edge and are latched at the third
        strap_sh_next = {strap_sh_reg[0], 1'b1};
        strap_done_next = strap_sh_reg[1];
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_reg <= 10'h000;
            pin_s2_reg <= 10'h000;
            irq_s1_reg <= 3'h0;
            irq_s2_reg <= 3'h0;
            strap_done_reg <= 1'b0;
            strap_sh_reg <= 2'h0;
        end
        else
        begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
            irq_s1_reg <= irq_s1_next;
            irq_s2_reg <= irq_s2_next;
            strap_done_reg <= strap_done_next;
            strap_sh_reg <= strap_sh_next;
        end
    end

    logic irq_any_s;
    logic reset_irq_s;
    logic rtc_irq_s;
    assign irq_any_s = irq_s2_reg[2];
    assign reset_irq_s = irq_s2_reg[1];
    assign rtc_irq_s = irq_s2_reg[0];

    function automatic logic [5:0] clamp_mult(input logic [5:0] m);
        if (m < pmc_pkg::MULT_MIN)
            clamp_mult = pmc_pkg::MULT_MIN;
        else if (m > pmc_pkg::MULT_MAX)
            clamp_mult = pmc_pkg::MULT_MAX;
        else
            clamp_mult = m;
    endfunction : clamp_mult

    function automatic logic [3:0] ssel_half(input logic [1:0] s);
        case (s)
            2'h0: ssel_half = pmc_pkg::SSEL_HALF_2;
            2'h1: ssel_half = pmc_pkg::SSEL_HALF_25;
            2'h2: ssel_half = pmc_pkg::SSEL_HALF_3;
            default: ssel_half = pmc_pkg::SSEL_HALF_4;
        endcase
    endfunction : ssel_half

    ////////////////////////////////////////////////////////////////////
    // pll control and mode state
    pmc_pkg::pmc_pll_s pll_reg;
    pmc_pkg::pmc_pll_s pll_next;
    pmc_pkg::pmc_mode_e mode_reg;
    pmc_pkg::pmc_mode_e mode_next;
    logic [13:0] pce_reg;
    logic [13:0] pce_next;
    always_comb
    begin
        pll_next = pll_reg;
        mode_next = mode_reg;
        pce_next = pce_reg;
        if (!strap_done_reg)
        begin
            pll_next.mult = clamp_mult(pin_s2_reg[9:4]);
            pll_next.bypass = pin_s2_reg[3];
            pll_next.div_in = pin_s2_reg[2];
            pll_next.ssel = pin_s2_reg[1:0];
            mode_next = pin_s2_reg[3] ? pmc_pkg::PMC_ACTIVE : pmc_pkg::PMC_FULL_ON;
        end
        else
        begin
            if (pce_wr && mode_reg != pmc_pkg::PMC_DEEP_SLEEP)
                pce_next = pce_wdata;
            if (pll_wr && mode_reg != pmc_pkg::PMC_DEEP_SLEEP)
            begin
                pll_next.mult = clamp_mult(pll_wdata.mult);
                pll_next.bypass = pll_wdata.bypass;
                pll_next.div_in = pll_wdata.div_in;
                pll_next.ssel = pll_wdata.ssel;
            end
            case (mode_reg)
                pmc_pkg::PMC_FULL_ON, pmc_pkg::PMC_ACTIVE:
                begin
                    if (seq_idle)
                    begin
                        case (mode_req)
                            pmc_pkg::PMC_REQ_RUN:
                                mode_next = pll_reg.bypass ? pmc_pkg::PMC_ACTIVE
                                                           : pmc_pkg::PMC_FULL_ON;
                            pmc_pkg::PMC_REQ_SLEEP: mode_next = pmc_pkg::PMC_SLEEP;
                            pmc_pkg::PMC_REQ_DEEP: mode_next = pmc_pkg::PMC_DEEP_SLEEP;
                            default: mode_next = mode_reg;
                        endcase
                    end
                end
                pmc_pkg::PMC_SLEEP:
                begin
                    if (irq_any_s || reset_irq_s || rtc_irq_s)
                        mode_next = pll_reg.bypass ? pmc_pkg::PMC_ACTIVE
                                                   : pmc_pkg::PMC_FULL_ON;
                end
                pmc_pkg::PMC_DEEP_SLEEP:
                begin
                    if (reset_irq_s)
                    begin
                        mode_next = pin_s2_reg[3] ? pmc_pkg::PMC_ACTIVE
                                                  : pmc_pkg::PMC_FULL_ON;
                        pll_next.bypass = pin_s2_reg[3];
                    end
                    else if (rtc_irq_s)
                    begin
                        mode_next = pmc_pkg::PMC_FULL_ON;
                        pll_next.bypass = 1'b0;
                    end
                end
                default: mode_next = pmc_pkg::PMC_FULL_ON;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pll_reg <= '{mult: pmc_pkg::MULT_MIN, bypass: 1'b0, div_in: 1'b0,
                         ssel: pmc_pkg::SSEL_RESET};
            mode_reg <= pmc_pkg::PMC_FULL_ON;
            pce_reg <= pmc_pkg::PCE_RESET;
        end
        else
        begin
            pll_reg <= pll_next;
            mode_reg <= mode_next;
            pce_reg <= pce_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // system clock divider (half-cycle counter in core clock units)
    logic [3:0] div_cnt_reg;
    logic [3:0] div_cnt_next;
    logic sclk_reg;
    logic sclk_next;
    logic [3:0] half_lim;

    always_comb
    begin
        half_lim = ssel_half(pll_reg.ssel);
        div_cnt_next = div_cnt_reg;
        sclk_next = sclk_reg;
        if (mode_reg == pmc_pkg::PMC_DEEP_SLEEP)
        begin
            div_cnt_next = 4'h0;
            sclk_next = 1'b0;
        end
        else if (div_cnt_reg >= (half_lim - 4'h1))
        begin
            div_cnt_next = 4'h0;
            sclk_next = ~sclk_reg;
        end
        else
            div_cnt_next = div_cnt_reg + 4'h1;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt_reg <= 4'h0;
            sclk_reg <= 1'b0;
        end
        else
        begin
            div_cnt_reg <= div_cnt_next;
            sclk_reg <= sclk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all registered, driven from the next mode, the next pll bypass bit and the next clock enable register value
    logic [13:0] oen_next;
    logic [7:0] flags_next;
    logic [13:0] oen_reg;
    logic [7:0] flags_reg;

    always_comb
    begin
        flags_next = 8'h00;
        oen_next = pce_next;
        case (mode_next)
            pmc_pkg::PMC_FULL_ON: flags_next = 8'hb2;
            pmc_pkg::PMC_ACTIVE: flags_next = 8'hfe;
            pmc_pkg::PMC_SLEEP:
                flags_next = {1'b1, pll_next.bypass, 2'h1, pll_next.bypass, 3'h2};
            pmc_pkg::PMC_DEEP_SLEEP:
            begin
                flags_next = 8'h01;
                oen_next = 14'h0000;
            end
            default: flags_next = 8'h00;
        endcase
    end

    // flags: pll_en, bypassed, core_en, sys_en, half, dma, async, deep
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_reg <= 8'h00;
            oen_reg <= 14'h0000;
        end
        else
        begin
            flags_reg <= flags_next;
            oen_reg <= oen_next;
        end
    end

    assign mode = mode_reg;
    assign pll_control_register = pll_reg;
    assign pll_enable = flags_reg[7];
    assign pll_bypassed = flags_reg[6];
    assign core_clk_en = flags_reg[5];
    assign sys_clk_en = flags_reg[4];
    assign core_half_rate = flags_reg[3];
    assign sys_dma_ok = flags_reg[2];
    assign async_access_ok = flags_reg[1];
    assign deep_sleep_ind = flags_reg[0];
    assign periph_clk_en = oen_reg;
    assign system_clock_output = sclk_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    deep_ind_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (deep_sleep_ind == (mode_reg == pmc_pkg::PMC_DEEP_SLEEP)))
        else $error("deep sleep indicator disagrees with mode");
    rtc_wake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_reg == pmc_pkg::PMC_DEEP_SLEEP && !reset_irq_s && rtc_irq_s && strap_done_reg)
        |=> (mode_reg == pmc_pkg::PMC_FULL_ON))
        else $error("rtc wake did not enter full on");
    deep_stay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_reg == pmc_pkg::PMC_DEEP_SLEEP && !reset_irq_s && !rtc_irq_s && strap_done_reg)
        |=> (mode_reg == pmc_pkg::PMC_DEEP_SLEEP))
        else $error("deep sleep left without reset or rtc");
    sleep_wake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_reg == pmc_pkg::PMC_SLEEP && irq_any_s && strap_done_reg)
        |=> (mode_reg == ($past(pll_reg.bypass) ? pmc_pkg::PMC_ACTIVE : pmc_pkg::PMC_FULL_ON)))
        else $error("sleep wake went to wrong mode");
    full_on_clk_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_reg == pmc_pkg::PMC_FULL_ON && strap_done_reg
        |-> (pll_enable && !pll_bypassed && core_clk_en && sys_clk_en))
        else $error("full on clock settings wrong");
    sleep_clk_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_reg == pmc_pkg::PMC_SLEEP |-> (!core_clk_en && sys_clk_en && !sys_dma_ok))
        else $error("sleep clock settings wrong");
    deep_clk_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_reg == pmc_pkg::PMC_DEEP_SLEEP
        |-> (!pll_enable && !core_clk_en && !sys_clk_en && periph_clk_en == 14'h0000))
        else $error("deep sleep clocks not stopped");
    active_dma_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_reg == pmc_pkg::PMC_ACTIVE |-> (sys_dma_ok && core_half_rate))
        else $error("active mode dma or half rate missing");
    no_sw_change_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (strap_done_reg && !seq_idle && (mode_reg == pmc_pkg::PMC_FULL_ON
         || mode_reg == pmc_pkg::PMC_ACTIVE)) |=> $stable(mode_reg))
        else $error("mode changed outside programming sequence");

endmodule : pmc_ctrl

// file: test/pmc_partner.sv
`timescale 1ns/1ps
// core-side software and wake-up sources
module pmc_partner (
    input wire logic core_clk,
    output logic [1:0] mode_req,
    output logic seq_idle,
    output logic irq_any,
    output logic reset_irq,
    output logic rtc_irq
);
    initial
    begin
        mode_req = pmc_pkg::PMC_REQ_NONE;
        seq_idle = 1'b0;
        irq_any = 1'b0;
        reset_irq = 1'b0;
        rtc_irq = 1'b0;
    end

    // idle flag driven together with the request code, both held for two cycles
    task request_mode(input logic [1:0] code, input logic idle);
        @(negedge core_clk);
        mode_req = code;
        seq_idle = idle;
        repeat (2) @(negedge core_clk);
        mode_req = pmc_pkg::PMC_REQ_NONE;
        seq_idle = 1'b0;
    endtask : request_mode

    // 0 any, 1 reset, 2 rtc
    task wake(input int src);
        @(negedge core_clk);
        irq_any = (src == 0);
        reset_irq = (src == 1);
        rtc_irq = (src == 2);
        repeat (6) @(negedge core_clk);
        {irq_any, reset_irq, rtc_irq} = 3'h0;
    endtask : wake
endmodule : pmc_partner

// file: test/pmc_ctrl_bench.sv
`timescale 1ns/1ps
module pmc_ctrl_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] mult_pin = 6'h06;
    logic bypass_pin = 1'b0;
    logic div_pin = 1'b0;
    logic [1:0] ssel_pin = 2'h2;
    logic pll_wr = 1'b0;
    pmc_pkg::pmc_pll_s pll_wdata = '0;
    logic pce_wr = 1'b0;
    logic [13:0] pce_wdata = 14'h0;
    logic [1:0] mode_req;
    logic seq_idle, irq_any, reset_irq, rtc_irq;
    logic [1:0] mode;
    pmc_pkg::pmc_pll_s pll_control_register;
    logic pll_enable, pll_bypassed, core_clk_en, sys_clk_en, core_half_rate;
    logic sys_dma_ok, async_access_ok, deep_sleep_ind, system_clock_output;
    logic [13:0] periph_clk_en;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int p;
    int tbl [4] = '{8, 10, 12, 16};

    always #2 core_clk = ~core_clk;

    pmc_partner pmc_partner_i (.core_clk(core_clk), .mode_req(mode_req), .seq_idle(seq_idle),
        .irq_any(irq_any), .reset_irq(reset_irq), .rtc_irq(rtc_irq));

    pmc_ctrl pmc_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .mult_pin(mult_pin),
        .bypass_pin(bypass_pin), .div_pin(div_pin), .ssel_pin(ssel_pin), .pll_wr(pll_wr),
        .pll_wdata(pll_wdata), .mode_req(mode_req), .seq_idle(seq_idle), .irq_any(irq_any),
        .reset_irq(reset_irq), .rtc_irq(rtc_irq), .pce_wr(pce_wr), .pce_wdata(pce_wdata),
        .mode(mode), .pll_control_register(pll_control_register), .pll_enable(pll_enable), .pll_bypassed(pll_bypassed),
        .core_clk_en(core_clk_en), .sys_clk_en(sys_clk_en), .core_half_rate(core_half_rate),
        .sys_dma_ok(sys_dma_ok), .async_access_ok(async_access_ok),
        .deep_sleep_ind(deep_sleep_ind), .periph_clk_en(periph_clk_en),
        .system_clock_output(system_clock_output));

    ////////////////////////////////////////////////////////////////////////////////
    task complete_run;
        if (err_total == 0 && check_count > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // flag vector checked under a mask of defined bits
    task flags(input logic [1:0] md, input logic [7:0] exp, input logic [7:0] msk);
        chk("mode", {14'h0, mode}, {14'h0, md});
        chk("flags", {8'h0, msk & {pll_enable, pll_bypassed, core_clk_en, sys_clk_en,
            core_half_rate, sys_dma_ok, async_access_ok, deep_sleep_ind}}, {8'h0, msk & exp});
    endtask : flags

    task settle;
        repeat (4) @(negedge core_clk);
    endtask : settle

    task wr_pll(input logic [5:0] m, input logic b, input logic [1:0] s);
        @(negedge core_clk);
        pll_wdata = '{mult: m, bypass: b, div_in: 1'b0, ssel: s};
        pll_wr = 1'b1;
        @(negedge core_clk);
        pll_wr = 1'b0;
    endtask : wr_pll

    // one full period of the system clock, from a falling edge
    task sclk_period(output int n);
        n = 0;
        while (system_clock_output !== 1'b1 && n < 40)
        begin
            @(negedge core_clk);
            n++;
        end
        while (system_clock_output === 1'b1 && n < 80)
        begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (system_clock_output === 1'b0 && n < 40)
        begin
            @(negedge core_clk);
            n++;
        end
        while (system_clock_output === 1'b1 && n < 80)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask : sclk_period

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        settle();
        flags(pmc_pkg::PMC_FULL_ON, 8'hb2, 8'hfb);
        chk("ssel", {14'h0, pll_control_register.ssel}, 16'h2);
        chk("mult", {10'h0, pll_control_register.mult}, 16'h6);
        chk("pce", {2'h0, periph_clk_en}, {2'h0, pmc_pkg::PCE_RESET});
        @(negedge core_clk);
        pce_wr = 1'b1;
        pce_wdata = 14'h2a55;
        @(negedge core_clk);
        pce_wr = 1'b0;
        settle();
        chk("pce", {2'h0, periph_clk_en}, 16'h2a55);
        pmc_partner_i.request_mode(pmc_pkg::PMC_REQ_SLEEP, 1'b0);
        settle();
        chk("mode", {14'h0, mode}, {14'h0, pmc_pkg::PMC_FULL_ON});
        for (int i = 0; i < 4; i++)
        begin
            wr_pll(6'h1f, 1'b0, i[1:0]);
            sclk_period(p);
            chk("sclk", p[15:0], tbl[i][15:0]);
        end
        chk("mult", {10'h0, pll_control_register.mult}, 16'h1f);
        wr_pll(6'h08, 1'b1, 2'h3);
        pmc_partner_i.request_mode(pmc_pkg::PMC_REQ_RUN, 1'b1);
        settle();
        flags(pmc_pkg::PMC_ACTIVE, 8'hfe, 8'hff);
        wr_pll(6'h08, 1'b1, 2'h1);
        settle();
        chk("ssel", {14'h0, pll_control_register.ssel}, 16'h1);
        pmc_partner_i.request_mode(pmc_pkg::PMC_REQ_SLEEP, 1'b1);
        settle();
        flags(pmc_pkg::PMC_SLEEP, 8'h92, 8'hb7);
        pmc_partner_i.wake(0);
        flags(pmc_pkg::PMC_ACTIVE, 8'hfe, 8'hff);
        wr_pll(6'h08, 1'b0, 2'h0);
        pmc_partner_i.request_mode(pmc_pkg::PMC_REQ_RUN, 1'b1);
        pmc_partner_i.request_mode(pmc_pkg::PMC_REQ_SLEEP, 1'b1);
        pmc_partner_i.wake(0);
        flags(pmc_pkg::PMC_FULL_ON, 8'hb2, 8'hfb);
        pmc_partner_i.request_mode(pmc_pkg::PMC_REQ_DEEP, 1'b1);
        settle();
        flags(pmc_pkg::PMC_DEEP_SLEEP, 8'h01, 8'hb3);
        chk("pce", {2'h0, periph_clk_en}, 16'h0);
        pmc_partner_i.wake(0);
        wr_pll(6'h02, 1'b0, 2'h3);
        settle();
        chk("mode", {14'h0, mode}, {14'h0, pmc_pkg::PMC_DEEP_SLEEP});
        chk("ssel", {14'h0, pll_control_register.ssel}, 16'h0);
        bypass_pin = 1'b1;
        pmc_partner_i.wake(2);
        flags(pmc_pkg::PMC_FULL_ON, 8'hb2, 8'hfb);
        pmc_partner_i.request_mode(pmc_pkg::PMC_REQ_DEEP, 1'b1);
        pmc_partner_i.wake(1);
        flags(pmc_pkg::PMC_ACTIVE, 8'hfe, 8'hff);
        complete_run();
    end
endmodule : pmc_ctrl_bench
